/* File: pga_pkg.sv */
package pga_pkg;
    // register index on the host register port
    localparam logic [1:0]  REG_CURRENT   = 2'h0;
    localparam logic [1:0]  REG_REMAINING = 2'h1;
    localparam logic [1:0]  REG_CHARGE    = 2'h2;
    localparam logic [1:0]  REG_DISCHARGE = 2'h3;
    // field layout
    localparam int          RESULT_W      = 11;
    localparam int          REG_W         = 16;
    localparam int          CAP_W         = 8;
    localparam int          TOTAL_W       = 16;
    localparam int          SIGN_COPIES   = REG_W - RESULT_W + 1;
    // scale: one result step is 0.005C, one total step is 0.16C
    localparam int          TOTAL_PER_CAP = 32;
    localparam logic [7:0]  CAP_FULL      = 8'hC8;
    localparam logic [7:0]  CAP_MAX       = 8'hFF;
    localparam logic [7:0]  CAP_EMPTY     = 8'h00;
    localparam logic [15:0] TOTAL_MAX     = 16'hFFFF;
    // reset values
    localparam logic [15:0] CURRENT_RST   = 16'h0000;
    localparam logic [7:0]  CAP_RST       = 8'h00;
    localparam logic [15:0] TOTAL_RST     = 16'h0000;
    // dead-band magnitudes, selected by the two threshold bits
    localparam logic [10:0] THR_NONE      = 11'h000;
    localparam logic [10:0] THR_2         = 11'h002;
    localparam logic [10:0] THR_4         = 11'h004;
    localparam logic [10:0] THR_8         = 11'h008;

    typedef struct packed {
        logic        wr;
        logic        rd_busy;
        logic [1:0]  addr;
        logic [15:0] wdata;
    } pga_host_req_type;
endpackage

/* File: pga_current_gauge.sv */
`timescale 1ns/100ps
// Summary of operation
// RL1: conversions start on their own, periodically
// RL2: low power halts conversions and drops new results; host writes still apply
// RL3: result is signed 11-bit, sign-extended to 16
// RL4: current reading frozen while host reads it
// RL5: count 200 equals 1C, span +-5.115C
// RL6: high byte holds bits 9:8 plus sign
// RL7: capacity counts up/down with current sign
// RL8: capacity counts to 255 and holds there
// RL9: capacity 200 is full, 0 is empty
// RL10: charge total on positive, discharge on negative
// RL11: totals are 16-bit, one step per 0.16C
// RL12: host may write totals, counting resumes from there
// RL13: host rescales capacity to 200 after full charge
// RL14: totals: low byte bits 7:0, high 15:8
// RL15: accumulator enable low stops all three counters
// RL16: results under selectable threshold are not accumulated
// RL17: fractional remainders make exact quantum steps
// RL18: capacity holds at zero, totals saturate
module pga_current_gauge #(
    parameter logic [23:0] CONV_PERIOD = 24'h0003E8,
    parameter int          CAP_QUANTUM = 1024
) (
    input  wire logic                      clk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      low_power_request_bit_i,
    input  wire logic                      accumulator_enable_bit_i,
    input  wire logic                      threshold_select_low_i,
    input  wire logic                      threshold_select_high_i,
    input  wire logic                      result_valid_i,
    input  wire logic [10:0]               result_i,
    input  wire pga_pkg::pga_host_req_type host_req_i,
    output logic                           conv_start_o,
    output logic [15:0]                    rd_data_o,
    output logic [15:0]                    current_reading_o
);
    localparam int TOTAL_QUANTUM = CAP_QUANTUM * pga_pkg::TOTAL_PER_CAP;

    logic [23:0] pace_cnt;
    logic [15:0] current_reading;
    logic [15:0] pending;
    logic        pending_valid;
    logic [7:0]  remaining_capacity_count;
    logic [15:0] charge_total_count;
    logic [15:0] discharge_total_count;
    logic signed [31:0] cap_rem;
    logic [31:0] chg_rem;
    logic [31:0] dchg_rem;

    logic        accept;
    logic        take;
    logic        negative;
    logic [10:0] magnitude;
    logic [10:0] threshold;
    logic [15:0] ext_result;
    logic signed [31:0] next_cap_rem;
    logic [31:0] next_chg_rem;
    logic [31:0] next_dchg_rem;

    // sign copies fill the upper six bits above bits 9:8
    function automatic logic [15:0] sign_extend(input logic [10:0] r);
        sign_extend = {{(pga_pkg::SIGN_COPIES - 1){r[10]}}, r}; // see RL3 see RL6
    endfunction

    function automatic logic host_writes(input pga_pkg::pga_host_req_type q,
                                         input logic [1:0] a);
        host_writes = q.wr && (q.addr == a);
    endfunction

    // dead-band decode
    always_comb begin
        case ({threshold_select_high_i, threshold_select_low_i})
            2'b01:   threshold = pga_pkg::THR_2; // see RL16
            2'b10:   threshold = pga_pkg::THR_4;
            2'b11:   threshold = pga_pkg::THR_8;
            default: threshold = pga_pkg::THR_NONE;
        endcase
    end

    // results arriving during low power are dropped entirely
    assign accept     = result_valid_i && !low_power_request_bit_i; // see RL2
    assign negative   = result_i[10];
    assign magnitude  = negative ? 11'(-result_i) : result_i;
    assign ext_result = sign_extend(result_i);
    assign take       = accept && accumulator_enable_bit_i          // see RL15
                        && (magnitude >= threshold) && (result_i != 11'h000); // see RL16

    // free-running pacing, no host command needed
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pace_cnt     <= 24'h000000;
            conv_start_o <= 1'b0;
        end else if (low_power_request_bit_i) begin
            pace_cnt     <= 24'h000000; // see RL2
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= (pace_cnt == 24'h000000); // see RL1
            pace_cnt     <= (pace_cnt == CONV_PERIOD - 24'h000001) ? 24'h000000
                                                                   : pace_cnt + 24'h000001;
        end
    end

    // a result landing mid-read waits in pending until the read ends
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            current_reading <= pga_pkg::CURRENT_RST;
            pending         <= pga_pkg::CURRENT_RST;
            pending_valid   <= 1'b0;
        end else if (host_req_i.rd_busy) begin
            if (accept) begin
                pending       <= ext_result; // see RL4
                pending_valid <= 1'b1;
            end
        end else begin
            pending_valid <= 1'b0;
            if (accept) begin
                current_reading <= ext_result; // see RL3 see RL5
            end else if (pending_valid) begin
                current_reading <= pending;
            end
        end
    end

    // remainders integrate charge in result-step x conversion units
    always_comb begin
        next_cap_rem  = cap_rem + 32'(signed'(result_i)); // see RL17
        next_chg_rem  = chg_rem + 32'(magnitude);
        next_dchg_rem = dchg_rem + 32'(magnitude);
    end

    // remaining capacity: 200 full, 0 empty; host write takes priority
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            remaining_capacity_count <= pga_pkg::CAP_RST;
            cap_rem                  <= 32'sh0;
        end else if (host_writes(host_req_i, pga_pkg::REG_REMAINING)) begin
            remaining_capacity_count <= host_req_i.wdata[7:0]; // see RL9 see RL13
        end else if (take) begin
            if (next_cap_rem >= CAP_QUANTUM) begin
                cap_rem <= next_cap_rem - CAP_QUANTUM;
                if (remaining_capacity_count != pga_pkg::CAP_MAX)
                    remaining_capacity_count <= remaining_capacity_count + 8'h01; // see RL7 see RL8
            end else if (next_cap_rem <= -CAP_QUANTUM) begin
                cap_rem <= next_cap_rem + CAP_QUANTUM;
                if (remaining_capacity_count != pga_pkg::CAP_EMPTY)
                    remaining_capacity_count <= remaining_capacity_count - 8'h01; // see RL18
            end else begin
                cap_rem <= next_cap_rem; // see RL17
            end
        end
    end

    // charge total, positive results only
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            charge_total_count <= pga_pkg::TOTAL_RST;
            chg_rem            <= 32'h0;
        end else if (host_writes(host_req_i, pga_pkg::REG_CHARGE)) begin
            charge_total_count <= host_req_i.wdata; // see RL12
        end else if (take && !negative) begin // see RL10
            if (next_chg_rem >= 32'(TOTAL_QUANTUM)) begin
                chg_rem <= next_chg_rem - 32'(TOTAL_QUANTUM);
                if (charge_total_count != pga_pkg::TOTAL_MAX)
                    charge_total_count <= charge_total_count + 16'h0001; // see RL11 see RL18
            end else begin
                chg_rem <= next_chg_rem;
            end
        end
    end

    // discharge total, negative results only
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            discharge_total_count <= pga_pkg::TOTAL_RST;
            dchg_rem              <= 32'h0;
        end else if (host_writes(host_req_i, pga_pkg::REG_DISCHARGE)) begin
            discharge_total_count <= host_req_i.wdata; // see RL12
        end else if (take && negative) begin // see RL10
            if (next_dchg_rem >= 32'(TOTAL_QUANTUM)) begin
                dchg_rem <= next_dchg_rem - 32'(TOTAL_QUANTUM);
                if (discharge_total_count != pga_pkg::TOTAL_MAX)
                    discharge_total_count <= discharge_total_count + 16'h0001; // see RL11
            end else begin
                dchg_rem <= next_dchg_rem;
            end
        end
    end

    // registered read data; counters read as plain storage when disabled
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rd_data_o <= 16'h0000;
        end else begin
            case (host_req_i.addr)
                pga_pkg::REG_CURRENT:   rd_data_o <= current_reading;
                pga_pkg::REG_REMAINING: rd_data_o <= {8'h00, remaining_capacity_count};
                pga_pkg::REG_CHARGE:    rd_data_o <= charge_total_count; // see RL14
                default:                rd_data_o <= discharge_total_count;
            endcase
        end
    end

    assign current_reading_o = current_reading;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    lp_no_start_a: assert property (low_power_request_bit_i |=> !conv_start_o) // see RL2
        else $error("conversion started in low power");
    lp_hold_a: assert property (low_power_request_bit_i && !host_req_i.wr
                                |=> $stable(remaining_capacity_count)) // see RL2
        else $error("capacity moved in low power");
    pace_pulse_a: assert property (conv_start_o |=> !conv_start_o) // see RL1
        else $error("start not a single pulse");
    pace_run_a: assert property (!low_power_request_bit_i [*8] ##0 pace_cnt == 24'h000000
                                 |=> conv_start_o) // see RL1
        else $error("start missing while running");
    read_freeze_a: assert property (host_req_i.rd_busy |=> $stable(current_reading)) // see RL4
        else $error("current changed during read");
    load_value_a: assert property (accept && !host_req_i.rd_busy
                                   |=> current_reading == sign_extend($past(result_i))) // see RL3
        else $error("current not loaded");
    sign_copy_a: assert property (current_reading[15:10] == {6{current_reading[10]}}) // see RL6
        else $error("high byte sign copies wrong");
    cap_top_a: assert property (remaining_capacity_count == pga_pkg::CAP_MAX && !host_req_i.wr
                                |=> remaining_capacity_count != pga_pkg::CAP_EMPTY) // see RL8
        else $error("capacity wrapped upward");
    cap_floor_a: assert property (remaining_capacity_count == pga_pkg::CAP_EMPTY
                                  && !host_req_i.wr
                                  |=> remaining_capacity_count != pga_pkg::CAP_MAX) // see RL18
        else $error("capacity wrapped downward");
    cap_dir_a: assert property (take && !negative && !host_req_i.wr
                                |=> remaining_capacity_count >= $past(remaining_capacity_count)) // see RL7
        else $error("capacity fell on charge");
    charge_dir_a: assert property (take && negative && !host_req_i.wr
                                   |=> $stable(charge_total_count)) // see RL10
        else $error("charge total moved on discharge");
    dis_dir_a: assert property (take && !negative && !host_req_i.wr
                                |=> $stable(discharge_total_count)) // see RL10
        else $error("discharge total moved on charge");
    total_step_a: assert property (!host_req_i.wr
                                   |=> 16'(charge_total_count - $past(charge_total_count))
                                       <= 16'h0001) // see RL11
        else $error("charge total stepped by more than one");
    total_write_a: assert property (host_writes(host_req_i, pga_pkg::REG_CHARGE)
                                    |=> charge_total_count == $past(host_req_i.wdata)) // see RL12
        else $error("charge total write lost");
    acc_off_a: assert property (!accumulator_enable_bit_i && !host_req_i.wr
                                |=> $stable(remaining_capacity_count)
                                    && $stable(discharge_total_count)) // see RL15
        else $error("counter moved while disabled");
    dead_band_a: assert property (result_valid_i && magnitude < threshold && !host_req_i.wr
                                  |=> $stable(cap_rem) && $stable(chg_rem)) // see RL16
        else $error("small result accumulated");

    charge_seen_c: cover property (take && !negative);
    discharge_seen_c: cover property (take && negative);
    held_update_c: cover property (host_req_i.rd_busy && accept ##[1:16] !host_req_i.rd_busy);
    cap_full_c: cover property (remaining_capacity_count == pga_pkg::CAP_FULL);
endmodule

/* File: pga_conv_model.sv */
`timescale 1ns/100ps
// converter on the far side of the gauge: answers each start request
// after one cycle (prompt) or three cycles (slow), always inside the period
module pga_conv_model (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        conv_start_i,
    input  wire logic [10:0] value_i,
    input  wire logic        slow_i,
    output logic             result_valid_o,
    output logic [10:0]      result_o
);
    logic [2:0] wait_cnt;

    // result lines toggle outside the valid pulse so stale data never looks good
    always_ff @(posedge clk_i) begin
        result_valid_o <= 1'b0;
        if (!resetn_i) begin
            wait_cnt <= 3'h0;
            result_o <= 11'h000;
        end else if (conv_start_i) begin
            wait_cnt <= slow_i ? 3'h3 : 3'h1;
            result_o <= ~result_o;
        end else begin
            result_o <= ~result_o;
            if (wait_cnt == 3'h1) begin
                result_valid_o <= 1'b1;
                result_o       <= value_i; // signed 11-bit sample
            end
            if (wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
            end
        end
    end
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    localparam int CAP_Q = 1024;
    logic                      clk;
    logic                      resetn;
    logic                      low_power;
    logic                      acc_en;
    logic                      thr_lo;
    logic                      thr_hi;
    logic                      slow;
    logic                      result_valid;
    logic [10:0]               result;
    logic [10:0]               value;
    pga_pkg::pga_host_req_type host_req;
    logic                      conv_start;
    logic [15:0]               rd_data;
    logic [15:0]               current_reading;
    int                        failures;
    int                        compares;
    int                        k;
    logic [10:0]               vals [4] = '{11'h3FF, 11'h401, 11'h7FF, 11'h738};
    logic [15:0]               exps [4] = '{16'h03FF, 16'hFC01, 16'hFFFF, 16'hFF38};
    logic [10:0]               thrs [4] = '{11'h001, 11'h002, 11'h004, 11'h008};

    pga_current_gauge #(.CONV_PERIOD(24'h000004), .CAP_QUANTUM(CAP_Q)) pga_current_gauge_inst (
        .clk_i(clk), .resetn_i(resetn), .low_power_request_bit_i(low_power),
        .accumulator_enable_bit_i(acc_en), .threshold_select_low_i(thr_lo),
        .threshold_select_high_i(thr_hi), .result_valid_i(result_valid), .result_i(result),
        .host_req_i(host_req), .conv_start_o(conv_start), .rd_data_o(rd_data),
        .current_reading_o(current_reading));

    pga_conv_model pga_conv_model_inst (
        .clk_i(clk), .resetn_i(resetn), .conv_start_i(conv_start), .value_i(value),
        .slow_i(slow), .result_valid_o(result_valid), .result_o(result));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic do_reset();
        @(posedge clk) resetn <= 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        host_req.wr    <= 1'b1;
        host_req.addr  <= a;
        host_req.wdata <= d;
        @(posedge clk) host_req.wr <= 1'b0;
    endtask

    // addr sampled one edge later, data settled just after that edge
    task automatic rchk(input string name, input logic [1:0] a, input logic [15:0] exp);
        @(posedge clk) host_req.addr <= a;
        @(posedge clk);
        #1 chk(name, exp, rd_data);
    endtask

    // let exactly n accepted results through, then park in low power
    task automatic run(input logic [10:0] v, input int n);
        int c;
        c = 0;
        @(posedge clk);
        value     <= v;
        low_power <= 1'b0;
        while (c < n) begin
            @(posedge clk);
            if (result_valid === 1'b1 && low_power === 1'b0) c++;
        end
        low_power <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    task automatic pace(input logic lp, input int exp);
        @(posedge clk) low_power <= lp;
        repeat (8) @(posedge clk);
        k = 0;
        repeat (40) begin
            @(posedge clk);
            #1 if (conv_start === 1'b1) k++;
        end
        chk("start_pulses", 16'(exp), 16'(k));
    endtask

    // stimulus: registers, pacing, format, freeze, accumulation, dead-band
    initial begin
        {resetn, low_power, acc_en, thr_lo, thr_hi, slow} = 6'h01;
        value = 11'h000;
        host_req = '0;
        failures = 0;
        compares = 0;
        do_reset();
        rchk("current", pga_pkg::REG_CURRENT, pga_pkg::CURRENT_RST);
        rchk("charge", pga_pkg::REG_CHARGE, pga_pkg::TOTAL_RST);
        wr(pga_pkg::REG_CURRENT, 16'h5A5A);
        rchk("current_ro", pga_pkg::REG_CURRENT, pga_pkg::CURRENT_RST);
        wr(pga_pkg::REG_REMAINING, 16'hABCD);
        rchk("remaining", pga_pkg::REG_REMAINING, 16'h00CD);
        wr(pga_pkg::REG_CHARGE, 16'hFFFE);
        rchk("charge", pga_pkg::REG_CHARGE, 16'hFFFE);
        wr(pga_pkg::REG_DISCHARGE, 16'h1234);
        rchk("discharge", pga_pkg::REG_DISCHARGE, 16'h1234);
        pace(1'b0, 10);
        pace(1'b1, 0);
        for (int i = 0; i < 4; i++) begin
            run(vals[i], 2);
            chk("reading", exps[i], current_reading);
        end
        rchk("reading_bus", pga_pkg::REG_CURRENT, 16'hFF38);
        rchk("remaining_off", pga_pkg::REG_REMAINING, 16'h00CD);
        rchk("charge_off", pga_pkg::REG_CHARGE, 16'hFFFE);
        @(posedge clk) host_req.rd_busy <= 1'b1;
        run(11'h014, 3);
        chk("frozen", 16'hFF38, current_reading);
        @(posedge clk) host_req.rd_busy <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("released", 16'h0014, current_reading);
        // charging from near the top, slow converter
        do_reset();
        acc_en <= 1'b1;
        slow   <= 1'b1;
        // host rescale after a full charge: capacity set to the full mark
        wr(pga_pkg::REG_REMAINING, {8'h00, pga_pkg::CAP_FULL});
        rchk("cap_full", pga_pkg::REG_REMAINING, {8'h00, pga_pkg::CAP_FULL});
        wr(pga_pkg::REG_REMAINING, 16'h00FE);
        run(11'h3FF, 66);
        rchk("cap_hold", pga_pkg::REG_REMAINING, {8'h00, pga_pkg::CAP_MAX});
        rchk("charge_pos", pga_pkg::REG_CHARGE, 16'((66 * 1023) / (32 * CAP_Q)));
        rchk("disch_pos", pga_pkg::REG_DISCHARGE, 16'h0000);
        // discharging from near empty, prompt converter
        do_reset();
        slow <= 1'b0;
        wr(pga_pkg::REG_REMAINING, 16'h0002);
        run(11'h401, 66);
        rchk("cap_floor", pga_pkg::REG_REMAINING, 16'h0000);
        rchk("disch_neg", pga_pkg::REG_DISCHARGE, 16'((66 * 1023) / (32 * CAP_Q)));
        rchk("charge_neg", pga_pkg::REG_CHARGE, 16'h0000);
        wr(pga_pkg::REG_DISCHARGE, 16'hFFFF);
        run(11'h401, 33);
        rchk("disch_sat", pga_pkg::REG_DISCHARGE, pga_pkg::TOTAL_MAX);
        // every dead-band code: at the edge counts (code 00 runs 1, above its zero edge); just below is ignored for the three nonzero codes
        for (int s = 0; s < 4; s++) begin
            do_reset();
            {thr_hi, thr_lo} <= 2'(s);
            if (s > 0) begin
                run(thrs[s] - 11'h001, 1024);
                rchk("below_thr", pga_pkg::REG_REMAINING, 16'h0000);
            end
            run(thrs[s], 1024);
            rchk("at_thr", pga_pkg::REG_REMAINING, 16'(thrs[s]));
        end
        tally_and_finish();
    end

    // hang guard, well beyond the roughly 30k cycles the sequence needs
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule
